// ===== core/crs_top.sv
// Clock tick generation and reset sequencing with AHB-Lite registers
//
// Functional notes
// [RULE1] A steady 25 MHz reference feeds oscillator and PLL.
// [RULE2] All subsystem clocks derive from the one 200 MHz base clock.
// [RULE3] A single-ended reference must toggle for the whole operation.
// [RULE4] Timer and free-running clock ticks also come from this block.
// [RULE5] Chip reset asserts every internal reset, latches straps, runs loader.
// [RULE6] Straps are captured once all chip reset sources are released.
// [RULE7] Loader starts after power-on, pin and digital resets.
// [RULE8] Digital reset covers all domains except the PHYs.
// [RULE9] Probe register reads invalid until serial domains leave reset.
// [RULE10] Ready flag stays clear during reset, sets when all is done.
// [RULE11] Before ready, only config, probe and reset control may be read.
// [RULE12] Writes before ready are ignored.
// [RULE13] Power-on reset lasts about 23 ms plus loader time; code uses PIN_CYCLES_P, as kind_reg reads RK_PIN after release.
// [RULE14] Pin low starts chip reset; host holds it the minimum width.
// [RULE15] Pin reset lasts about 760 us plus loader time.
// [RULE16] Setting the digital reset bit starts the multi-module reset.
// [RULE17] Digital reset keeps the straps latched at the last chip reset.
// [RULE18] Sticky register bits survive the digital reset.
// [RULE19] Digital reset lasts about 760 us plus loader time.
// [RULE20] A PHY reset touches only that PHY; no straps, no loader.
// [RULE21] PHY request bits clear themselves when the PHY reset ends.
// [RULE22] Pin release is synchronised; digital bit clears when done.
`timescale 1ns/1ps
`default_nettype none
module crs_top
    import crs_pkg::*;
#(
    parameter int unsigned POR_CYCLES_P = POR_CYCLES,
    parameter int unsigned PIN_CYCLES_P = PIN_CYCLES,
    parameter int unsigned DIG_CYCLES_P = DIG_CYCLES,
    parameter int unsigned PHY_CYCLES_P = PHY_RST_CYCLES
) (
    input wire logic CLK_I,                  // Base clock, 125 MHz
    input wire logic RSTN_I,                 // Power-on reset, active low
    input wire logic RESET_PIN_N_I,          // Reset pin, active low
    input wire logic [STRAP_W-1:0] STRAP_I,  // Strap pins
    input wire logic EE_DONE_I,              // Loader finished, level
    input wire logic HSEL_I,                 // AHB select
    input wire logic [7:0] HADDR_I,          // AHB address
    input wire logic [1:0] HTRANS_I,         // AHB transfer type
    input wire logic HWRITE_I,               // AHB write
    input wire logic [2:0] HSIZE_I,          // AHB size
    input wire logic [31:0] HWDATA_I,        // AHB write data
    input wire logic HREADY_I,               // AHB bus ready
    output logic [31:0] HRDATA_O,            // AHB read data
    output logic HREADYOUT_O,                // AHB slave ready
    output logic HRESP_O,                    // AHB response
    output logic [DOM_N-1:0] DOM_RST_N_O,    // Domain resets, active low
    output logic PHY1_RST_N_O,               // Port 1 PHY reset, low
    output logic PHY2_RST_N_O,               // Port 2 PHY reset, low
    output logic VPHY_RST_N_O,               // Management PHY reset, low
    output logic [STRAP_W-1:0] STRAP_O,      // Latched straps
    output logic EE_START_O,                 // Loader start pulse
    output logic READY_O,                    // Device ready
    output logic GPT_TICK_O,                 // General timer tick
    output logic FRC_TICK_O                  // Free-running clock tick
);

    // Pin synchronisers
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic [STRAP_W-1:0] strap_meta_reg;
    logic [STRAP_W-1:0] strap_sync_reg;

    // Sequencer state
    crs_state_t state_reg;
    crs_kind_t kind_reg;
    logic [31:0] cnt_reg;
    logic [DOM_N-1:0] dom_rst_n_reg;
    logic ready_reg;
    logic ser_ok_reg;
    logic strap_pend_reg;
    logic [STRAP_W-1:0] strap_reg;
    logic ee_start_reg;
    logic dig_bit_reg;

    // Software registers
    logic [31:0] scratch_reg;
    logic [31:0] sticky_reg;

    // Bus data phase
    logic wr_pend_reg;
    logic [7:0] addr_reg;
    logic [31:0] hrdata_reg;

    // PHY reset status
    logic phy1_busy;
    logic phy2_busy;
    logic vphy_busy;

    logic chip_hold;
    logic [31:0] base_limit;
    logic base_end;
    logic ser_end;
    logic ahb_take;
    logic wr_ok;
    logic wr_rstctl;
    logic wr_dig;
    logic rd_allowed;
    logic [31:0] rd_value;
    logic [31:0] hwcfg_value;
    logic [31:0] rstctl_value;

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            strap_meta_reg <= STRAP_RST;
            strap_sync_reg <= STRAP_RST;
        end else begin
            pin_meta_reg <= RESET_PIN_N_I;  // [RULE22]
            pin_sync_reg <= pin_meta_reg;
            strap_meta_reg <= STRAP_I;
            strap_sync_reg <= strap_meta_reg;
        end
    end

    // Pin reset acts only after the two-stage synchroniser
    assign chip_hold = ~pin_sync_reg;  // [RULE14]

    // Base reset time chosen by kind_reg; after power-on it reads RK_PIN, so the pin time applies
    assign base_limit = (kind_reg == RK_POR) ? 32'(POR_CYCLES_P) :  // [RULE13]
                        (kind_reg == RK_PIN) ? 32'(PIN_CYCLES_P) :  // [RULE15]
                        32'(DIG_CYCLES_P);  // [RULE19]
    assign base_end = (state_reg == ST_HOLD) &&
                      (cnt_reg == base_limit - 32'h0000_0001);
    assign ser_end = (state_reg == ST_HOLD) &&
                     (cnt_reg == 32'(SER_REL_CYCLES - 1));

    // Bus decode; only whole-word transfers are taken
    assign ahb_take = HSEL_I && HTRANS_I[1] && HREADY_I &&
                      (HSIZE_I == 3'b010);
    assign wr_ok = wr_pend_reg && ready_reg;  // [RULE12]
    assign wr_rstctl = wr_ok && (addr_reg == RSTCTL_OFS);
    assign wr_dig = wr_rstctl && HWDATA_I[RST_DIGITAL_BIT];  // [RULE16]

    assign hwcfg_value = {16'h0000, strap_reg, 7'h00, ready_reg};
    assign rstctl_value = {28'h0000000, vphy_busy, phy2_busy, phy1_busy,
                           dig_bit_reg};

    // Until ready only the three status registers answer
    assign rd_allowed = ready_reg || (HADDR_I == PROBE_OFS) ||  // [RULE11]
                        (HADDR_I == HWCFG_OFS) || (HADDR_I == RSTCTL_OFS);
    assign rd_value =
        !rd_allowed ? 32'h0000_0000 :
        (HADDR_I == PROBE_OFS) ?
            (ser_ok_reg ? PROBE_VALUE : 32'h0000_0000) :  // [RULE9]
        (HADDR_I == HWCFG_OFS) ? hwcfg_value :
        (HADDR_I == RSTCTL_OFS) ? rstctl_value :
        (HADDR_I == SCRATCH_OFS) ? scratch_reg :
        (HADDR_I == STICKY_OFS) ? sticky_reg :
        32'h0000_0000;

    // Bus slave: zero wait states, always OKAY
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            wr_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
            hrdata_reg <= 32'h0000_0000;
        end else begin
            if (HREADY_I) begin
                wr_pend_reg <= ahb_take && HWRITE_I;
                addr_reg <= HADDR_I;
            end
            if (ahb_take && !HWRITE_I) begin
                hrdata_reg <= rd_value;
            end
        end
    end

    // Reset sequencer
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I || chip_hold) begin
            // Chip reset: every domain held, straps to be re-latched
            state_reg <= ST_HOLD;  // [RULE5]
            kind_reg <= RSTN_I ? RK_PIN : RK_POR;
            cnt_reg <= 32'h0000_0000;
            dom_rst_n_reg <= '0;
            ready_reg <= 1'b0;  // [RULE10]
            ser_ok_reg <= 1'b0;
            strap_pend_reg <= 1'b1;
            ee_start_reg <= 1'b0;
            dig_bit_reg <= 1'b0;
            scratch_reg <= SCRATCH_RST;
            sticky_reg <= STICKY_RST;
        end else begin
            ee_start_reg <= 1'b0;
            if (strap_pend_reg) begin
                // First cycle with every chip reset source released
                strap_reg <= strap_sync_reg;  // [RULE6]
                strap_pend_reg <= 1'b0;
            end
            if (wr_ok && addr_reg == SCRATCH_OFS) begin
                scratch_reg <= HWDATA_I;
            end
            if (wr_ok && addr_reg == STICKY_OFS) begin
                sticky_reg <= HWDATA_I;
            end
            case (state_reg)
                ST_HOLD: begin
                    cnt_reg <= cnt_reg + 32'h0000_0001;
                    if (ser_end) begin
                        // Serial slaves come up first so the probe can answer
                        ser_ok_reg <= 1'b1;  // [RULE9]
                        dom_rst_n_reg[DOM_I2C] <= 1'b1;
                        dom_rst_n_reg[DOM_SMI] <= 1'b1;
                    end
                    if (base_end) begin
                        dom_rst_n_reg <= '1;
                        ee_start_reg <= 1'b1;  // [RULE7]
                        state_reg <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    // Loader time per byte adds on top of the base time
                    if (EE_DONE_I && !ee_start_reg) begin
                        ready_reg <= 1'b1;  // [RULE10]
                        dig_bit_reg <= 1'b0;  // [RULE22]
                        state_reg <= ST_READY;
                    end
                end
                ST_READY: begin
                    if (wr_dig) begin
                        // Straps, sticky bits and PHYs are left alone
                        state_reg <= ST_HOLD;  // [RULE17]
                        kind_reg <= RK_DIG;
                        cnt_reg <= 32'h0000_0000;
                        dom_rst_n_reg <= '0;  // [RULE8]
                        ready_reg <= 1'b0;
                        ser_ok_reg <= 1'b0;
                        dig_bit_reg <= 1'b1;
                        scratch_reg <= SCRATCH_RST;  // [RULE18]
                    end
                end
                default: begin
                    state_reg <= ST_HOLD;
                end
            endcase
        end
    end

    // PHY resets see only chip-level holds, never the digital reset
    crs_phy_rst #(.CYCLES(PHY_CYCLES_P)) u_phy1 (
        .CLK_I(CLK_I),
        .RSTN_I(RSTN_I),
        .hold_i(chip_hold),
        .start_i(wr_rstctl && HWDATA_I[RST_PHY1_BIT]),  // [RULE20]
        .busy_o(phy1_busy),  // [RULE21]
        .rst_n_o(PHY1_RST_N_O)
    );

    crs_phy_rst #(.CYCLES(PHY_CYCLES_P)) u_phy2 (
        .CLK_I(CLK_I),
        .RSTN_I(RSTN_I),
        .hold_i(chip_hold),
        .start_i(wr_rstctl && HWDATA_I[RST_PHY2_BIT]),  // [RULE20]
        .busy_o(phy2_busy),  // [RULE21]
        .rst_n_o(PHY2_RST_N_O)
    );

    crs_phy_rst #(.CYCLES(VPHY_RST_CYCLES)) u_vphy (
        .CLK_I(CLK_I),
        .RSTN_I(RSTN_I),
        .hold_i(chip_hold),
        .start_i(wr_rstctl && HWDATA_I[RST_VPHY_BIT]),  // [RULE20]
        .busy_o(vphy_busy),
        .rst_n_o(VPHY_RST_N_O)
    );

    // CLK_I stands in for the PLL base clock fed by the reference
    crs_tick_div #(.DIV(GPT_DIV)) u_gpt_div (  // [RULE2] [RULE1]
        .CLK_I(CLK_I),
        .RSTN_I(RSTN_I),
        .tick_o(GPT_TICK_O)  // [RULE4]
    );

    crs_tick_div #(.DIV(FRC_DIV)) u_frc_div (
        .CLK_I(CLK_I),
        .RSTN_I(RSTN_I),
        .tick_o(FRC_TICK_O)  // [RULE4]
    );

    // Output flops and the fixed bus ready and response straight to ports
    assign HRDATA_O = hrdata_reg;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;
    assign DOM_RST_N_O = dom_rst_n_reg;
    assign STRAP_O = strap_reg;
    assign EE_START_O = ee_start_reg;
    assign READY_O = ready_reg;

endmodule // crs_top
`default_nettype wire

// ===== pkg/crs_pkg.sv
// Shared constants and types for the clock and reset sequencer
package crs_pkg;

    // Clock plan: the 25 MHz reference feeds the PLL base clock
    localparam int REF_CLK_MHZ = 25;
    localparam int BASE_CLK_MHZ = 200;
    localparam int CLK_MHZ = 125;

    // Reset durations in microseconds
    localparam int POR_TIME_US = 23000;
    localparam int PIN_TIME_US = 760;
    localparam int DIG_TIME_US = 760;
    localparam int PHY_RST_TIME_US = 110;
    localparam int VPHY_RST_TIME_US = 1;
    localparam int EE_BYTE_TIME_US = 91;

    // Derived cycle counts at CLK_MHZ
    localparam int POR_CYCLES = POR_TIME_US * CLK_MHZ;
    localparam int PIN_CYCLES = PIN_TIME_US * CLK_MHZ;
    localparam int DIG_CYCLES = DIG_TIME_US * CLK_MHZ;
    localparam int PHY_RST_CYCLES = PHY_RST_TIME_US * CLK_MHZ;
    localparam int VPHY_RST_CYCLES = VPHY_RST_TIME_US * CLK_MHZ;
    localparam int SER_REL_CYCLES = 16;

    // Timer tick dividers (1 MHz timer, 25 MHz free-running)
    localparam int GPT_DIV = 125;
    localparam int FRC_DIV = 5;

    // Register byte offsets
    localparam logic [7:0] PROBE_OFS = 8'h00;
    localparam logic [7:0] HWCFG_OFS = 8'h04;
    localparam logic [7:0] RSTCTL_OFS = 8'h08;
    localparam logic [7:0] SCRATCH_OFS = 8'h0c;
    localparam logic [7:0] STICKY_OFS = 8'h10;

    // Reset control fields
    localparam int RST_DIGITAL_BIT = 0;
    localparam int RST_PHY1_BIT = 1;
    localparam int RST_PHY2_BIT = 2;
    localparam int RST_VPHY_BIT = 3;

    // Hardware config fields
    localparam int HWCFG_READY_BIT = 0;
    localparam int HWCFG_STRAP_LSB = 8;
    localparam int STRAP_W = 8;

    // Reset values
    localparam logic [31:0] SCRATCH_RST = 32'h0000_0000;
    localparam logic [31:0] STICKY_RST = 32'h0000_0000;
    localparam logic [STRAP_W-1:0] STRAP_RST = 8'h00;
    // Arbitrary byte-order probe constant
    localparam logic [31:0] PROBE_VALUE = 32'h1357_9bdf;

    // Reset domains driven by the sequencer
    localparam int DOM_SYS = 0;
    localparam int DOM_IRQ = 1;
    localparam int DOM_FABRIC = 2;
    localparam int DOM_PMI = 3;
    localparam int DOM_I2C = 4;
    localparam int DOM_SMI = 5;
    localparam int DOM_EEC = 6;
    localparam int DOM_GPIO = 7;
    localparam int DOM_N = 8;

    typedef enum logic [1:0] {ST_HOLD, ST_LOAD, ST_READY} crs_state_t;
    typedef enum logic [1:0] {RK_POR, RK_PIN, RK_DIG} crs_kind_t;

endpackage

// ===== core/crs_tick_div.sv
// Divider producing a one-cycle enable tick
`timescale 1ns/1ps
`default_nettype none
module crs_tick_div #(
    parameter int unsigned DIV = 125
) (
    input wire logic CLK_I,   // Base clock
    input wire logic RSTN_I,  // Sync reset, active low
    output logic tick_o       // One-cycle enable
);
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic wrap;

    assign wrap = (cnt_reg == 16'(DIV - 1));
    assign cnt_next = wrap ? 16'h0000 : cnt_reg + 16'h0001;

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            cnt_reg <= 16'h0000;
            tick_o <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_o <= wrap;
        end
    end
endmodule // crs_tick_div
`default_nettype wire

// ===== core/crs_phy_rst.sv
// Single-module reset timer with self-clearing busy flag
`timescale 1ns/1ps
`default_nettype none
module crs_phy_rst #(
    parameter int unsigned CYCLES = 13750
) (
    input wire logic CLK_I,    // Base clock
    input wire logic RSTN_I,   // Sync reset, active low
    input wire logic hold_i,   // Chip-level reset active
    input wire logic start_i,  // Request pulse from software
    output logic busy_o,       // Request bit, clears when done
    output logic rst_n_o       // Module reset, active low
);
    logic [31:0] cnt_reg;
    logic done;

    assign done = busy_o && (cnt_reg == 32'(CYCLES - 1));

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I || hold_i) begin
            cnt_reg <= 32'h0000_0000;
            busy_o <= 1'b0;
            rst_n_o <= 1'b0;
        end else if (start_i) begin
            // A new request wins over completion in the same cycle
            cnt_reg <= 32'h0000_0000;
            busy_o <= 1'b1;
            rst_n_o <= 1'b0;
        end else if (done) begin
            busy_o <= 1'b0;
            rst_n_o <= 1'b1;
        end else begin
            cnt_reg <= busy_o ? cnt_reg + 32'h0000_0001 : 32'h0000_0000;
            rst_n_o <= ~busy_o;
        end
    end
endmodule // crs_phy_rst
`default_nettype wire

// ===== verification/crs_monitor.sv
// Checker on the sequencer top-level ports
`timescale 1ns/1ps
`default_nettype none
module crs_monitor
    import crs_pkg::*;
#(
    parameter int PHY_CYCLES_P = 20
) (
    input wire logic CLK_I,                  // Base clock
    input wire logic RSTN_I,                 // Power-on reset, low
    input wire logic RESET_PIN_N_I,          // Reset pin, low
    input wire logic EE_DONE_I,              // Loader finished
    input wire logic HSEL_I,                 // AHB select
    input wire logic [7:0] HADDR_I,          // AHB address
    input wire logic [1:0] HTRANS_I,         // AHB transfer type
    input wire logic HWRITE_I,               // AHB write
    input wire logic [2:0] HSIZE_I,          // AHB size
    input wire logic [31:0] HWDATA_I,        // AHB write data
    input wire logic HREADY_I,               // AHB bus ready
    input wire logic [DOM_N-1:0] DOM_RST_N_O,  // Domain resets
    input wire logic PHY1_RST_N_O,           // Port 1 PHY reset
    input wire logic [STRAP_W-1:0] STRAP_O,  // Latched straps
    input wire logic EE_START_O,             // Loader start pulse
    input wire logic READY_O,                // Device ready
    input wire logic GPT_TICK_O,             // Timer tick
    input wire logic FRC_TICK_O              // Free-running tick
);
    localparam int PHY_LO = PHY_CYCLES_P - 1;
    localparam int PHY_HI = PHY_CYCLES_P + 2;
    logic ctl_wr_reg;
    wire logic ctl_wr_next = HSEL_I && HTRANS_I[1] && HREADY_I && HWRITE_I
        && HSIZE_I == 3'b010 && HADDR_I == RSTCTL_OFS;
    always_ff @(posedge CLK_I) ctl_wr_reg <= RSTN_I && ctl_wr_next;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    AST_POR_HOLD: assert property (disable iff (1'b0)
        !RSTN_I |=> DOM_RST_N_O == '0 && !READY_O && !EE_START_O)
        else $error("Power-on reset left a domain or ready active");
    AST_READY_DOMS: assert property (READY_O |-> &DOM_RST_N_O)
        else $error("Ready while a domain is still in reset");
    AST_READY_CAUSE: assert property (
        $rose(READY_O) |-> $past(EE_DONE_I))
        else $error("Ready rose without loader completion");
    AST_START_PULSE: assert property (
        EE_START_O |=> !EE_START_O && !READY_O)
        else $error("Loader start not a single pulse");
    AST_PIN_HOLD: assert property (
        !RESET_PIN_N_I [*4] |=> DOM_RST_N_O == '0 && !READY_O)
        else $error("Pin reset did not reset the domains");
    AST_STRAP_KEEP: assert property (
        READY_O && RESET_PIN_N_I && $past(RESET_PIN_N_I) |=> $stable(STRAP_O))
        else $error("Straps changed without a chip reset");
    AST_DIG_START: assert property (
        ctl_wr_reg && HWDATA_I[RST_DIGITAL_BIT] && READY_O
        |=> DOM_RST_N_O == '0 && !READY_O && PHY1_RST_N_O)
        else $error("Digital reset request not carried out");
    AST_PHY_HOLD: assert property (
        READY_O && $fell(PHY1_RST_N_O)
        |-> (!PHY1_RST_N_O && &DOM_RST_N_O && READY_O) [*8])
        else $error("Port 1 reset disturbed other modules");
    AST_PHY_END: assert property (
        READY_O && $fell(PHY1_RST_N_O)
        |-> ##[PHY_LO:PHY_HI] $rose(PHY1_RST_N_O))
        else $error("Port 1 reset length wrong");
    AST_FRC_GAP: assert property (
        FRC_TICK_O |=> !FRC_TICK_O [*4])
        else $error("Free-running tick too close");
    AST_GPT_GAP: assert property (
        GPT_TICK_O |=> !GPT_TICK_O [*8])
        else $error("Timer tick too close");
endmodule // crs_monitor

bind crs_top crs_monitor #(.PHY_CYCLES_P(PHY_CYCLES_P)) u_mon (.*);
`default_nettype wire

// ===== verification/crs_loader_model.sv
// Behavioural loader answering each start pulse after a delay
`timescale 1ns/1ps
`default_nettype none
module crs_loader_model #(
    parameter int DELAY = 6
) (
    input wire logic clk_i,    // Base clock
    input wire logic rstn_i,   // Sync reset, active low
    input wire logic start_i,  // Loader start pulse
    output var logic done_o    // Load finished, level
);
    int cnt = 0;
    initial done_o = 1'b0;
    always @(posedge clk_i) begin
        if (!rstn_i || start_i) begin
            done_o <= 1'b0; // Busy again on every run
            cnt <= DELAY;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else begin
            done_o <= 1'b1;
        end
    end
endmodule // crs_loader_model
`default_nettype wire

// ===== verification/crs_top_tb.sv
// Self-checking bench for the clock and reset sequencer
`timescale 1ns/1ps
`default_nettype none
module crs_top_tb;
    import crs_pkg::*;
    localparam int SEQ = 40;
    localparam int PHYC = 20;
    localparam int LDLY = 6;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic pin_n = 1'b1;
    logic [7:0] strap = 8'ha5;
    logic hsel = 1'b0;
    logic hwr = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, v;
    logic [7:0] dom, strap_o;
    logic hready, hresp, phy1, phy2, vphy, ee_start, ee_done, ready, gpt, frc;
    int num_errors = 0;
    int checked = 0;
    int starts = 0;
    int cyc = 0;
    int t0, s0, f, g;
    wire logic [3:0] phyn = {vphy, phy2, phy1, 1'b1};

    crs_top #(.POR_CYCLES_P(SEQ), .PIN_CYCLES_P(SEQ), .DIG_CYCLES_P(SEQ),
        .PHY_CYCLES_P(PHYC)) DUT (.CLK_I(clk), .RSTN_I(rstn),
        .RESET_PIN_N_I(pin_n), .STRAP_I(strap), .EE_DONE_I(ee_done),
        .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwr),
        .HSIZE_I(3'b010), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .DOM_RST_N_O(dom), .PHY1_RST_N_O(phy1), .PHY2_RST_N_O(phy2),
        .VPHY_RST_N_O(vphy), .STRAP_O(strap_o), .EE_START_O(ee_start),
        .READY_O(ready), .GPT_TICK_O(gpt), .FRC_TICK_O(frc));
    crs_loader_model #(.DELAY(LDLY)) u_ld (.clk_i(clk), .rstn_i(rstn),
        .start_i(ee_start), .done_o(ee_done));

    initial begin
        forever #4 clk = ~clk; // Runs without pause
    end
    always @(posedge clk) cyc++;
    always @(negedge clk) if (ee_start === 1'b1) starts++;

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwr <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        chk("response", 32'h0, {31'h0, hresp});
    endtask

    task automatic rdchk(input string what, input logic [7:0] a,
        input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        chk(what, exp, d & m);
    endtask

    // Polls a field, then checks how long the wait took
    task automatic poll(input string what, input logic [7:0] a,
        input logic [31:0] m, input logic [31:0] exp, input int hi);
        logic [31:0] d;
        int n;
        n = 0;
        do begin
            bus(1'b0, a, 32'h0, d);
            n++;
        end while ((d & m) !== exp && n < 200);
        chk(what, exp, d & m);
        chk(what, 32'h1, {31'h0, cyc - t0 <= hi});
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        num_errors++;
        end_of_test();
    end

    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t0 = cyc;
        rdchk("early probe", PROBE_OFS, '1, 32'h0);
        rdchk("early ready", HWCFG_OFS, 32'h1, 32'h0);
        bus(1'b1, SCRATCH_OFS, 32'hdead_beef, v);
        poll("probe", PROBE_OFS, '1, PROBE_VALUE, SEQ);
        poll("ready", HWCFG_OFS, 32'h1, 32'h1, SEQ + LDLY + 16);
        rdchk("straps", HWCFG_OFS, 32'hff00, 32'ha500);
        chk("strap pins", 32'ha5, {24'h0, strap_o});
        rdchk("early write", SCRATCH_OFS, '1, 32'h0);
        rdchk("unmapped", 8'h20, '1, 32'h0);
        chk("loader runs", 32'h1, starts);
        $display("Power-up test done");

        bus(1'b1, SCRATCH_OFS, 32'h1234_5678, v);
        bus(1'b1, STICKY_OFS, 32'hcafe_0001, v);
        rdchk("scratch", SCRATCH_OFS, '1, 32'h1234_5678);
        strap <= 8'h3c;
        s0 = starts;
        t0 = cyc;
        bus(1'b1, RSTCTL_OFS, 32'h1, v);
        rdchk("digital bit", RSTCTL_OFS, 32'h1, 32'h1);
        chk("domains", 32'h0, {23'h0, dom & 8'hcf, ready});
        chk("phys kept", 32'hf, {28'h0, phyn});
        poll("probe", PROBE_OFS, '1, PROBE_VALUE, SEQ);
        poll("ready", HWCFG_OFS, 32'h1, 32'h1, SEQ + LDLY + 16);
        rdchk("straps", HWCFG_OFS, 32'hff00, 32'ha500);
        chk("strap pins", 32'ha5, {24'h0, strap_o});
        rdchk("sticky", STICKY_OFS, '1, 32'hcafe_0001);
        rdchk("scratch", SCRATCH_OFS, '1, 32'h0);
        rdchk("digital bit", RSTCTL_OFS, 32'h1, 32'h0);
        chk("loader reruns", s0 + 1, starts);
        $display("Digital reset test done");

        for (int b = 1; b < 4; b++) begin
            s0 = starts;
            t0 = cyc;
            bus(1'b1, RSTCTL_OFS, 32'h1 << b, v);
            rdchk("phy busy", RSTCTL_OFS, 32'hf, 32'h1 << b);
            chk("phy pins", 32'hf ^ (32'h1 << b), {28'h0, phyn});
            chk("others", 32'h1ff, {23'h0, dom, ready});
            poll("phy done", RSTCTL_OFS, 32'hf, 32'h0,
                (b == 3 ? VPHY_RST_CYCLES : PHYC) + 12);
            chk("phy pins", 32'hf, {28'h0, phyn});
            chk("no loader", s0, starts);
        end
        rdchk("straps", HWCFG_OFS, 32'hff00, 32'ha500);
        $display("Module reset test done");

        f = 0;
        g = 0;
        repeat (250) @(negedge clk) begin
            f += frc;
            g += gpt;
        end
        chk("fast ticks", 32'd50, f);
        chk("timer ticks", 32'd2, g);
        $display("Tick test done");

        s0 = starts;
        @(posedge clk);
        pin_n <= 1'b0;
        repeat (4) @(posedge clk);
        pin_n <= 1'b1;
        @(negedge clk);
        t0 = cyc;
        chk("pin reset", 32'h0, {20'h0, dom, phyn[3:1], ready});
        poll("probe", PROBE_OFS, '1, PROBE_VALUE, SEQ);
        poll("ready", HWCFG_OFS, 32'h1, 32'h1, SEQ + LDLY + 16);
        rdchk("straps", HWCFG_OFS, 32'hff00, 32'h3c00);
        chk("strap pins", 32'h3c, {24'h0, strap_o});
        chk("loader runs", s0 + 1, starts);
        $display("Pin reset test done");
        end_of_test();
    end
endmodule // crs_top_tb
`default_nettype wire
